// >>> include/cbi_pkg.sv
// constants and state type for the capture buffer and interrupt enable block
package cbi_pkg;
    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    localparam int ADDR_W = 4;                        // register address width
    localparam logic [3:0] OFS_ENABLES = 4'h0;        // timer_interrupt_enables
    localparam logic [3:0] OFS_FLAGS = 4'h1;          // timer_flag_reg
    localparam logic [3:0] OFS_CONTROL = 4'h6;        // timer_control_reg
    localparam logic [3:0] OFS_CAP_A_HI = 4'h8;       // capture_reg_a high byte
    localparam logic [3:0] OFS_CAP_A_LO = 4'h9;       // capture_reg_a low byte
    localparam logic [3:0] OFS_CAP_B_HI = 4'hA;       // capture_reg_b high byte
    localparam logic [3:0] OFS_CAP_B_LO = 4'hB;       // capture_reg_b low byte
    localparam logic [3:0] OFS_CAP_C_HI = 4'hC;       // capture_reg_c high byte
    localparam logic [3:0] OFS_CAP_C_LO = 4'hD;       // capture_reg_c low byte
    localparam logic [3:0] OFS_CAP_D_HI = 4'hE;       // capture_reg_d high byte
    localparam logic [3:0] OFS_CAP_D_LO = 4'hF;       // capture_reg_d low byte
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BIT_CAP_A = 7;                     // capture a enable / flag
    localparam int BIT_CAP_B = 6;                     // capture b enable / flag
    localparam int BIT_CAP_C = 5;                     // capture c enable / flag
    localparam int BIT_CAP_D = 4;                     // capture d enable / flag
    localparam int BIT_CMP_A = 3;                     // compare a enable / flag
    localparam int BIT_CMP_B = 2;                     // compare b enable / flag
    localparam int BIT_WRAP = 1;                      // overflow enable / wrap flag
    localparam int BIT_FIXED = 0;                     // reserved enable bit / counter clear a
    localparam int CTL_EDGE_A = 7;                    // edge_select_a
    localparam int CTL_EDGE_B = 6;                    // edge_select_b
    localparam int CTL_EDGE_C = 5;                    // edge_select_c
    localparam int CTL_EDGE_D = 4;                    // edge_select_d
    localparam int CTL_BUF_AC = 3;                    // buffer_enable_pair_ac
    localparam int CTL_BUF_BD = 2;                    // buffer_enable_pair_bd
    localparam int CTL_CKS_HI = 1;                    // clock select msb
    localparam int CTL_CKS_LO = 0;                    // clock select lsb
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] ENABLES_RST = 8'h01;       // enables word, bit 0 fixed high
    localparam logic [7:0] CONTROL_RST = 8'h00;       // control word
    localparam logic [7:0] FLAGS_RST = 8'h00;         // flag word
    localparam logic [15:0] CAPTURE_RST = 16'h0000;   // each capture register
    // ----------------------------------------------------------------
    // timing the pin source must meet
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 40000;             // 25 MHz system clock
    localparam int MIN_PULSE_SINGLE_PS = 60000;       // 1.5 clock periods
    localparam int MIN_PULSE_BOTH_PS = 100000;        // 2.5 clock periods
    localparam int MIN_PULSE_SINGLE_CYC =
        (MIN_PULSE_SINGLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int MIN_PULSE_BOTH_CYC =
        (MIN_PULSE_BOTH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // ----------------------------------------------------------------
    // whole state of the block
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:1] irqEn;          // interrupt enables
        logic [7:1] flag;           // event flags
        logic [7:1] armed;          // flags seen as 1 by a read
        logic cclrA;                // counter clear a control bit
        logic [7:0] ctrl;           // control register
        logic [3:0][15:0] cap;      // capture registers, index 0..3 = a..d
        logic [7:0] temp;           // low byte held for a paired read
        logic [3:0][2:0] sync;      // pin synchronisers
        logic [3:0] pinLvl;         // accepted pin levels
        logic [7:0] rdData;         // read answer
    } cbi_state_t;
endpackage

// >>> hdl/cbi_capture_unit.sv
// capture buffering, edge selection, event flags and interrupt enables
// Behaviour
// - buffered a: old a to c, count to a
// - buffered b: old b to d, count to b
// - buffered: differing pair edge bits make pin a or b capture both edges
// - buffered pair: 00 falling, mixed both, 11 rising
// - reset and standby clear capture registers
// - high byte read latches low into holding
// - enables initialise to 01 hex
// - enable bit 7 gates capture a request
// - enable bit 6 gates capture b request
// - enable bit 5 gates capture c request
// - enable bit 4 gates capture d request
// - enable bit 3 gates compare a request
// - enable bit 2 gates compare b request
// - enable bit 1 gates overflow request
// - enable bit 0 reads 1, ignores writes
// - buffered a: pin c only sets flag
// - flags cleared by read one, write zero
// - control: edges 7-4, buffers 3-2, clock 1-0
`timescale 1ns/1ns
module cbi_capture_unit
    import cbi_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic standbyEntry,
    input wire logic [15:0] freeCounter,
    input wire logic capturePinA,
    input wire logic capturePinB,
    input wire logic capturePinC,
    input wire logic capturePinD,
    input wire logic compareMatchA,
    input wire logic compareMatchB,
    input wire logic counterWrap,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    output logic [1:0] clockSelect,
    output logic counterClearA,
    output logic captureARequest,
    output logic captureBRequest,
    output logic captureCRequest,
    output logic captureDRequest,
    output logic compareARequest,
    output logic compareBRequest,
    output logic overflowRequest
);
    // ----------------------------------------------------------------
    // state and helpers
    // ----------------------------------------------------------------
    cbi_state_t st_ff;        // registered state
    cbi_state_t nxt_st;       // next state
    logic [3:0] pinRise;      // accepted rising edge per pin
    logic [3:0] pinFall;      // accepted falling edge per pin
    logic [3:0] trig;         // capture or flag trigger per pin
    logic bufAc;              // pair a/c buffered
    logic bufBd;              // pair b/d buffered

    // trigger decode shared by all four pins
    function automatic logic edgeHit(input logic rise, input logic fall,
                                     input logic sel, input logic pairSel,
                                     input logic bufOn);
        logic hit;
        hit = sel ? rise : fall;
        if (bufOn && (sel != pairSel)) begin
            hit = rise | fall;
        end
        return hit;
    endfunction

    // edge accepted once stages two and three agree on a new level
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_edge
            assign pinRise[gi] = (st_ff.sync[gi][1] == st_ff.sync[gi][2])
                && (st_ff.sync[gi][2] != st_ff.pinLvl[gi]) && st_ff.sync[gi][2];
            assign pinFall[gi] = (st_ff.sync[gi][1] == st_ff.sync[gi][2])
                && (st_ff.sync[gi][2] != st_ff.pinLvl[gi]) && !st_ff.sync[gi][2];
        end
    endgenerate

    assign bufAc = st_ff.ctrl[CTL_BUF_AC];
    assign bufBd = st_ff.ctrl[CTL_BUF_BD];

    // trigger selection per pin
    assign trig[0] = edgeHit(pinRise[0], pinFall[0], st_ff.ctrl[CTL_EDGE_A],
                             st_ff.ctrl[CTL_EDGE_C], bufAc);
    assign trig[1] = edgeHit(pinRise[1], pinFall[1], st_ff.ctrl[CTL_EDGE_B],
                             st_ff.ctrl[CTL_EDGE_D], bufBd);
    assign trig[2] = edgeHit(pinRise[2], pinFall[2], st_ff.ctrl[CTL_EDGE_C],
                             st_ff.ctrl[CTL_EDGE_C], 1'b0);
    assign trig[3] = edgeHit(pinRise[3], pinFall[3], st_ff.ctrl[CTL_EDGE_D],
                             st_ff.ctrl[CTL_EDGE_D], 1'b0);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [7:1] evSet;
        logic [7:1] clr;
        evSet = '0;
        clr = '0;
        nxt_st = st_ff;
        if (clkEn) begin
            nxt_st.rdData = 8'h00;
            // synchronisers and accepted levels
            for (int i = 0; i < 4; i++) begin
                nxt_st.sync[i] = {st_ff.sync[i][1:0], 1'b0};
                if (st_ff.sync[i][1] == st_ff.sync[i][2]) begin
                    nxt_st.pinLvl[i] = st_ff.sync[i][2];
                end
            end
            nxt_st.sync[0][0] = capturePinA;
            nxt_st.sync[1][0] = capturePinB;
            nxt_st.sync[2][0] = capturePinC;
            nxt_st.sync[3][0] = capturePinD;
            // register reads, answer stands one cycle
            if (regRd) begin
                case (regAddr)
                    OFS_ENABLES: nxt_st.rdData = {st_ff.irqEn, 1'b1};
                    OFS_FLAGS: begin
                        nxt_st.rdData = {st_ff.flag, st_ff.cclrA};
                        nxt_st.armed = st_ff.armed | st_ff.flag;
                    end
                    OFS_CONTROL: nxt_st.rdData = st_ff.ctrl;
                    OFS_CAP_A_HI: begin
                        nxt_st.rdData = st_ff.cap[0][15:8];
                        nxt_st.temp = st_ff.cap[0][7:0];
                    end
                    OFS_CAP_B_HI: begin
                        nxt_st.rdData = st_ff.cap[1][15:8];
                        nxt_st.temp = st_ff.cap[1][7:0];
                    end
                    OFS_CAP_C_HI: begin
                        nxt_st.rdData = st_ff.cap[2][15:8];
                        nxt_st.temp = st_ff.cap[2][7:0];
                    end
                    OFS_CAP_D_HI: begin
                        nxt_st.rdData = st_ff.cap[3][15:8];
                        nxt_st.temp = st_ff.cap[3][7:0];
                    end
                    OFS_CAP_A_LO, OFS_CAP_B_LO,
                    OFS_CAP_C_LO, OFS_CAP_D_LO: nxt_st.rdData = st_ff.temp;
                    default: nxt_st.rdData = 8'h00;
                endcase
            end
            // register writes; capture registers are read only
            if (regWr) begin
                case (regAddr)
                    OFS_ENABLES: nxt_st.irqEn = regWrData[7:1];
                    OFS_FLAGS: begin
                        clr = st_ff.armed & ~regWrData[7:1];
                        nxt_st.flag = st_ff.flag & ~clr;
                        nxt_st.armed = '0;
                        nxt_st.cclrA = regWrData[BIT_FIXED];
                    end
                    OFS_CONTROL: nxt_st.ctrl = regWrData;
                    default: nxt_st.ctrl = st_ff.ctrl;
                endcase
            end
            // capture pair a/c
            if (trig[0]) begin
                if (bufAc) begin
                    nxt_st.cap[2] = st_ff.cap[0];
                end
                nxt_st.cap[0] = freeCounter;
            end
            if (trig[2] && !bufAc) begin
                nxt_st.cap[2] = freeCounter;
            end
            // capture pair b/d
            if (trig[1]) begin
                if (bufBd) begin
                    nxt_st.cap[3] = st_ff.cap[1];
                end
                nxt_st.cap[1] = freeCounter;
            end
            if (trig[3] && !bufBd) begin
                nxt_st.cap[3] = freeCounter;
            end
            // hardware sets win over a same-cycle clear
            evSet[BIT_CAP_A] = trig[0];
            evSet[BIT_CAP_B] = trig[1];
            evSet[BIT_CAP_C] = trig[2];
            evSet[BIT_CAP_D] = trig[3];
            evSet[BIT_CMP_A] = compareMatchA;
            evSet[BIT_CMP_B] = compareMatchB;
            evSet[BIT_WRAP] = counterWrap;
            nxt_st.flag = nxt_st.flag | evSet;
            // standby entry initialises registers
            if (standbyEntry) begin
                nxt_st.cap = {4{CAPTURE_RST}};
                nxt_st.irqEn = ENABLES_RST[7:1];
                nxt_st.ctrl = CONTROL_RST;
                nxt_st.flag = FLAGS_RST[7:1];
                nxt_st.cclrA = FLAGS_RST[BIT_FIXED];
                nxt_st.armed = '0;
                nxt_st.temp = 8'h00;
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_ff <= '0;
            st_ff.irqEn <= ENABLES_RST[7:1];
            st_ff.ctrl <= CONTROL_RST;
            st_ff.cap <= {4{CAPTURE_RST}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign regRdData = st_ff.rdData;
    assign clockSelect = st_ff.ctrl[CTL_CKS_HI:CTL_CKS_LO];
    assign counterClearA = st_ff.cclrA;
    // each request is its flag gated by its enable
    assign captureARequest = st_ff.flag[BIT_CAP_A] & st_ff.irqEn[BIT_CAP_A];
    assign captureBRequest = st_ff.flag[BIT_CAP_B] & st_ff.irqEn[BIT_CAP_B];
    assign captureCRequest = st_ff.flag[BIT_CAP_C] & st_ff.irqEn[BIT_CAP_C];
    assign captureDRequest = st_ff.flag[BIT_CAP_D] & st_ff.irqEn[BIT_CAP_D];
    assign compareARequest = st_ff.flag[BIT_CMP_A] & st_ff.irqEn[BIT_CMP_A];
    assign compareBRequest = st_ff.flag[BIT_CMP_B] & st_ff.irqEn[BIT_CMP_B];
    assign overflowRequest = st_ff.flag[BIT_WRAP] & st_ff.irqEn[BIT_WRAP];

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // capture path, register and request checks
    AST_BUF_A_SHIFT: assert property (clkEn && trig[0] && bufAc && !standbyEntry |=>
        st_ff.cap[2] == $past(st_ff.cap[0]) && st_ff.cap[0] == $past(freeCounter))
        else $error("buffered capture a did not shift");
    AST_BUF_B_SHIFT: assert property (clkEn && trig[1] && bufBd && !standbyEntry |=>
        st_ff.cap[3] == $past(st_ff.cap[1]) && st_ff.cap[1] == $past(freeCounter))
        else $error("buffered capture b did not shift");
    AST_BOTH_EDGES: assert property (clkEn && bufAc && !standbyEntry
        && (st_ff.ctrl[CTL_EDGE_A] != st_ff.ctrl[CTL_EDGE_C]) && (pinRise[0] || pinFall[0])
        |=> st_ff.flag[BIT_CAP_A])
        else $error("mixed edge bits missed an edge");
    AST_FALL_ONLY: assert property (clkEn && bufAc && !st_ff.ctrl[CTL_EDGE_A]
        && !st_ff.ctrl[CTL_EDGE_C] && pinRise[0] |-> !trig[0])
        else $error("falling edge mode fired on rising edge");
    AST_STANDBY_CLEAR: assert property (clkEn && standbyEntry |=>
        st_ff.cap == {4{CAPTURE_RST}})
        else $error("standby left capture registers set");
    AST_TEMP_PAIR: assert property (clkEn && regRd && regAddr == OFS_CAP_A_HI && !standbyEntry
        ##1 clkEn && regRd && regAddr == OFS_CAP_A_LO |=>
        regRdData == $past(st_ff.cap[0][7:0], 2))
        else $error("low byte not from holding register");
    AST_ENABLE_INIT: assert property (clkEn && standbyEntry |=>
        st_ff.irqEn == ENABLES_RST[7:1] && !captureARequest)
        else $error("enables not initialised");
    AST_REQ_HOLD: assert property (captureARequest
        && !(clkEn && (regWr || standbyEntry)) |=> captureARequest)
        else $error("capture a request dropped without a write");
    AST_FIXED_BIT: assert property (clkEn && regRd && regAddr == OFS_ENABLES |=>
        regRdData[BIT_FIXED])
        else $error("reserved enable bit read as 0");
    AST_PIN_C_FLAG: assert property (clkEn && bufAc && trig[2] && !trig[0]
        && !standbyEntry |=> st_ff.cap[2] == $past(st_ff.cap[2]) && st_ff.flag[BIT_CAP_C])
        else $error("pin c captured in buffered mode");
    AST_NO_SW_SET: assert property (clkEn && regWr && regAddr == OFS_FLAGS
        && !st_ff.flag[BIT_CMP_A] && !compareMatchA |=> !st_ff.flag[BIT_CMP_A])
        else $error("software set a flag");
    AST_CTRL_WRITE: assert property (clkEn && regWr && regAddr == OFS_CONTROL
        && !standbyEntry |=> st_ff.ctrl == $past(regWrData) && clockSelect == $past(regWrData[1:0]))
        else $error("control write not stored");
    AST_ENABLE_WRITE: assert property (clkEn && regWr && regAddr == OFS_ENABLES
        && !standbyEntry |=> st_ff.irqEn == $past(regWrData[7:1]))
        else $error("enable write not stored");
    // flag clearing and hardware set priority
    AST_FLAG_CLEAR: assert property (clkEn && regWr && regAddr == OFS_FLAGS
        && st_ff.armed[BIT_WRAP] && !regWrData[BIT_WRAP] && !counterWrap && !standbyEntry
        |=> !st_ff.flag[BIT_WRAP])
        else $error("armed flag not cleared by a zero write");
    AST_CLR_NEEDS_READ: assert property (clkEn && regWr && regAddr == OFS_FLAGS
        && st_ff.flag[BIT_CMP_A] && !st_ff.armed[BIT_CMP_A] && !standbyEntry
        |=> st_ff.flag[BIT_CMP_A])
        else $error("flag cleared without an earlier read");
    AST_SET_WINS: assert property (clkEn && counterWrap && !standbyEntry |=>
        st_ff.flag[BIT_WRAP])
        else $error("wrap event lost against a clear");

    // coverage of the main scenarios
    COV_BUF_A: cover property (clkEn && trig[0] && bufAc);
    COV_PIN_C_ONLY: cover property (clkEn && bufAc && trig[2] && !trig[0]);
    COV_BOTH_EDGE: cover property (clkEn && bufAc && pinRise[0] && trig[0]
        && st_ff.ctrl[CTL_EDGE_A] != st_ff.ctrl[CTL_EDGE_C]);
    COV_FLAG_CLEAR: cover property (st_ff.flag[BIT_CAP_A] ##1 clkEn && regWr
        && regAddr == OFS_FLAGS ##1 !st_ff.flag[BIT_CAP_A]);
    COV_REQ: cover property (overflowRequest);
endmodule

// >>> tb/capture_buffer_irq_enable_tb_top.sv
// self-checking testbench for the capture buffer and interrupt enable unit
`timescale 1ns/1ns
module capture_buffer_irq_enable_tb_top;
    import cbi_pkg::*;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic sys_clk, srst, clkEn, standbyEntry, regWr, regRd;
    logic capturePinA, capturePinB, capturePinC, capturePinD;
    logic compareMatchA, compareMatchB, counterWrap;
    logic [15:0] freeCounter;
    logic [3:0] regAddr;
    logic [7:0] regWrData, regRdData, rv;
    logic [1:0] clockSelect;
    logic counterClearA, reqA, reqB, reqC, reqD, reqCmpA, reqCmpB, reqWrap;
    logic [15:0] mP, mS, cnt, got;
    logic eP, eS;
    int failures = 0;
    int samplesChecked = 0;
    cbi_capture_unit cbi_capture_unit_i (.sys_clk(sys_clk), .srst(srst), .clkEn(clkEn),
        .standbyEntry(standbyEntry), .freeCounter(freeCounter), .capturePinA(capturePinA),
        .capturePinB(capturePinB), .capturePinC(capturePinC), .capturePinD(capturePinD),
        .compareMatchA(compareMatchA), .compareMatchB(compareMatchB),
        .counterWrap(counterWrap), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .clockSelect(clockSelect),
        .counterClearA(counterClearA), .captureARequest(reqA), .captureBRequest(reqB),
        .captureCRequest(reqC), .captureDRequest(reqD), .compareARequest(reqCmpA),
        .compareBRequest(reqCmpB), .overflowRequest(reqWrap));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    // clock: 40 ns period
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // final verdict, reached from the main sequence or the watchdog
    task automatic conclude();
        $display("checks %0d failures %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // compare one value and count it
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
        #1; // callers look once the write has landed
    endtask
    // one-cycle read strobe, data taken in the following cycle only
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 d = regRdData;
    endtask
    // paired read, back to back: high byte first, low byte from the holding register
    task automatic rd16(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regAddr <= a + 4'h1;
        #1 d[15:8] = regRdData;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 d[7:0] = regRdData;
    endtask
    // drive a pin level and give the synchroniser time to pass it
    task automatic pin(input int p, input logic v);
        @(posedge sys_clk);
        if (p == 0) capturePinA <= v;
        else if (p == 1) capturePinB <= v;
        else capturePinC <= v;
        repeat (8) @(posedge sys_clk);
    endtask
    // buffered pair: differing bits give both edges, equal bits pick one edge
    function automatic logic hit(input logic p, input logic s, input logic rising);
        return (p != s) || (p == rising);
    endfunction
    // watchdog against a hung run
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        conclude();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {srst, clkEn, standbyEntry, regWr, regRd} = 5'b11000;
        {capturePinA, capturePinB, capturePinC, capturePinD} = 4'h0;
        {compareMatchA, compareMatchB, counterWrap} = 3'b000;
        {freeCounter, regAddr, regWrData} = 28'h000_0000;
        void'($urandom(32'he3ad_a77a));
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        // reset values
        rd(OFS_ENABLES, rv); check("enables", rv, 16'h0001);
        rd(OFS_CONTROL, rv); check("control", rv, 16'h0000);
        rd16(OFS_CAP_A_HI, got); check("capA", got, 16'h0000);
        // enables and control read back, bit 0 fixed high
        repeat (4) begin
            cnt = 16'($urandom());
            wr(OFS_ENABLES, cnt[7:0]);
            rd(OFS_ENABLES, rv); check("enables", rv, {8'h00, cnt[7:1], 1'b1});
            wr(OFS_CONTROL, cnt[15:8]);
            rd(OFS_CONTROL, rv); check("control", rv, {8'h00, cnt[15:8]});
            check("clockSelect", clockSelect, {14'h0, cnt[9:8]});
        end
        // compare and wrap events gated by their enables
        wr(OFS_ENABLES, 8'h0E);
        @(posedge sys_clk);
        {compareMatchA, compareMatchB, counterWrap} <= 3'b111;
        @(posedge sys_clk);
        {compareMatchA, compareMatchB, counterWrap} <= 3'b000;
        repeat (2) @(posedge sys_clk);
        check("cmpReqs", {reqCmpA, reqCmpB, reqWrap}, 16'h0007);
        wr(OFS_ENABLES, 8'h00);
        check("cmpReqsOff", {reqCmpA, reqCmpB, reqWrap}, 16'h0000);
        wr(OFS_ENABLES, 8'h0E);
        wr(OFS_FLAGS, 8'hFF);
        check("cmpReqsHeld", {reqCmpA, reqCmpB, reqWrap}, 16'h0007);
        check("counterClearA", counterClearA, 16'h0001);
        rd(OFS_FLAGS, rv); check("flags", rv, 16'h000F);
        wr(OFS_FLAGS, 8'h00);
        @(posedge sys_clk);
        check("cmpReqsClr", {counterClearA, reqCmpA, reqCmpB, reqWrap}, 16'h0000);
        // buffered capture, every edge-select combination on both pairs
        for (int p = 0; p < 2; p++) begin
            mP = 16'h0000;
            mS = 16'h0000;
            for (int k = 0; k < 4; k++) begin
                eP = k[1];
                eS = k[0];
                wr(OFS_CONTROL, p ? {1'b0, eP, 1'b0, eS, 4'h4} : {eP, 1'b0, eS, 1'b0, 4'h8});
                for (int v = 1; v >= 0; v--) begin
                    cnt = 16'($urandom());
                    freeCounter <= cnt;
                    pin(p, v[0]);
                    if (hit(eP, eS, v[0])) begin
                        mS = mP;
                        mP = cnt;
                    end
                    rd16(4'(8 + 2 * p), got); check("capPrimary", got, mP);
                    rd16(4'(12 + 2 * p), got); check("capBuffer", got, mS);
                end
            end
        end
        // pin c in buffered a/c mode raises only its flag
        rd16(OFS_CAP_C_HI, mS);
        wr(OFS_CONTROL, 8'h28);
        freeCounter <= 16'h5A5A;
        pin(2, 1'b1);
        pin(2, 1'b0);
        rd16(OFS_CAP_C_HI, got); check("capCKept", got, mS);
        wr(OFS_ENABLES, 8'hF0);
        check("capReqs", {reqA, reqB, reqC, reqD}, 16'h000E);
        wr(OFS_ENABLES, 8'h10);
        check("capReqsOff", {reqA, reqB, reqC, reqD}, 16'h0000);
        // standby entry initialises registers
        @(posedge sys_clk);
        standbyEntry <= 1'b1;
        @(posedge sys_clk);
        standbyEntry <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd16(4'(8 + 2 * i), got); check("capStandby", got, 16'h0000);
        end
        rd(OFS_ENABLES, rv); check("enablesStandby", rv, 16'h0001);
        // a write while the clock enable is low must not land
        @(posedge sys_clk);
        clkEn <= 1'b0;
        wr(OFS_ENABLES, 8'hFE);
        @(posedge sys_clk);
        clkEn <= 1'b1;
        rd(OFS_ENABLES, rv); check("enablesFrozen", rv, 16'h0001);
        conclude();
    end
endmodule
